// ---- pad_router_regs.svh ----
`ifndef PAD_ROUTER_REGS_SVH
`define PAD_ROUTER_REGS_SVH

// pad row geometry
`define PR_NUM_GROUPS 4
`define PR_SLOTS 16
`define PR_SEL_W 4
`define PR_DIR_W 2
`define PR_ALL_SLOTS 64

// which slots of each group may drive a pad
`define PR_G0_OUT_CAP 16'hFC7F
`define PR_G1_OUT_CAP 16'hFFFC
`define PR_G2_OUT_CAP 16'hFFE6
`define PR_G3_OUT_CAP 16'hFF8C

// which slots of each group may listen to a pad
`define PR_G0_IN_CAP 16'hC387
`define PR_G1_IN_CAP 16'hF8EF
`define PR_G2_IN_CAP 16'hFC1F
`define PR_G3_IN_CAP 16'hFC7F

// idle level of every input slot with no pad (active-low ones sit high)
`define PR_IN_IDLE 64'h0073_0009_0003_0080

// flat slot indices (group * 16 + slot) of the debug, line-driver, select and parallel port slots
`define PR_SLOT_DEBUG 6'h00
`define PR_SLOT_D0 6'h01
`define PR_SLOT_D4 6'h02
`define PR_SLOT_TX_ACTIVE 6'h05
`define PR_SLOT_RXF_N 6'h06
`define PR_SLOT_HOST_SEL_B_N 6'h0A
`define PR_SLOT_D1 6'h12
`define PR_SLOT_D5 6'h13
`define PR_SLOT_TXE_N 6'h14
`define PR_SLOT_D2 6'h21
`define PR_SLOT_D6 6'h22
`define PR_SLOT_RD_N 6'h23
`define PR_SLOT_D3 6'h32
`define PR_SLOT_D7 6'h33
`define PR_SLOT_WR_N 6'h34
`define PR_SLOT_HOST_SEL_A_N 6'h37

// reset state of a pad's selector
`define PR_SEL_RESET 4'h0

`endif

// ---- pad_router_pkg.sv ----
package pad_router_pkg;

  // pad direction; code 3 of a raw 2-bit field is illegal
  typedef enum logic [1:0] {
    PAD_INPUT,
    PAD_OUTPUT,
    PAD_BIDIR
  } pad_dir_e;

  // one pad's routing choice
  typedef struct packed {
    pad_dir_e dir;
    logic [3:0] sel;
  } pad_cfg_s;

endpackage

// ---- fifo_strobe_if.sv ----
`timescale 1ns/1ps
// strobes, data and flags between the pad router and the parallel port
interface fifo_strobe_if;
  logic wr_n; // write strobe as seen at the pads
  logic rd_n; // read strobe as seen at the pads
  logic [7:0] din; // byte gathered from the data pads
  logic [7:0] dout; // byte offered to the data pads
  logic dout_en; // data pads driven while high
  logic txe_n; // high forbids an external write
  logic rxf_n; // low while a byte may be read

  modport engine (
    input wr_n,
    input rd_n,
    input din,
    output dout,
    output dout_en,
    output txe_n,
    output rxf_n
  );

  modport router (
    output wr_n,
    output rd_n,
    output din,
    input dout,
    input dout_en,
    input txe_n,
    input rxf_n
  );
endinterface

// ---- pad_lane.sv ----
`timescale 1ns/1ps
`include "pad_router_regs.svh"

// one pad: picks a slot of its own group and decides drive and listen
module pad_lane #(
  parameter int GROUP = 0
) (
  input wire logic [15:0] group_out,
  input wire logic [15:0] group_oe,
  input wire pad_router_pkg::pad_dir_e dir,
  input wire logic [3:0] sel,
  output logic drive_val,
  output logic drive_en,
  output logic rx_en
);

  // capability masks of this lane's group
  localparam logic [15:0] OUT_CAP = (GROUP == 0) ? `PR_G0_OUT_CAP :
                                    (GROUP == 1) ? `PR_G1_OUT_CAP :
                                    (GROUP == 2) ? `PR_G2_OUT_CAP :
                                                   `PR_G3_OUT_CAP;
  localparam logic [15:0] IN_CAP = (GROUP == 0) ? `PR_G0_IN_CAP :
                                   (GROUP == 1) ? `PR_G1_IN_CAP :
                                   (GROUP == 2) ? `PR_G2_IN_CAP :
                                                  `PR_G3_IN_CAP;

  // input-only slots never drive, output-only slots never listen
  wire can_out = OUT_CAP[sel]; // RQ14
  wire can_in = IN_CAP[sel]; // RQ14
  wire is_out = (dir == pad_router_pkg::PAD_OUTPUT);
  wire is_bidir = (dir == pad_router_pkg::PAD_BIDIR);

  // only the one selected slot reaches the pad
  assign drive_val = group_out[sel]; // RQ17
  // output pads drive always if the slot can drive, two-way pads when the slot also asks to
  assign drive_en = can_out & (is_out | (is_bidir & group_oe[sel])); // RQ4
  // input and two-way pads feed their slot
  assign rx_en = can_in & ~is_out; // RQ13

endmodule // pad_lane

// ---- fifo_strobe_port.sv ----
`timescale 1ns/1ps

// parallel byte port: one-byte transmit and receive holding stages
module fifo_strobe_port (
  input wire logic clk,
  input wire logic rst_n,
  fifo_strobe_if.engine pins,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_pop,
  input wire logic [7:0] rx_byte,
  input wire logic rx_load,
  output logic rx_room
);

  logic wr_prev_ff; // last write strobe level
  logic rd_prev_ff; // last read strobe level
  logic tx_full_ff; // transmit stage holds a byte
  logic [7:0] tx_ff; // captured write byte
  logic rx_full_ff; // receive stage holds a byte
  logic [7:0] rx_ff; // byte waiting to be read
  logic [7:0] out_ff; // byte presented while the read strobe is low

  wire wr_fall = wr_prev_ff & ~pins.wr_n;
  wire rd_fall = rd_prev_ff & ~pins.rd_n;
  // a write while the flag forbids it is dropped, nothing to overwrite
  wire wr_take = wr_fall & ~tx_full_ff;
  wire rd_take = rd_fall & rx_full_ff;

  // strobe history, idle high so reset never fakes an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
    end else begin
      wr_prev_ff <= pins.wr_n;
      rd_prev_ff <= pins.rd_n;
    end
  end

  // transmit stage: capture on the falling write strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (wr_take) begin
      tx_full_ff <= 1'b1; // RQ10
      tx_ff <= pins.din; // RQ10
    end else if (tx_pop) begin
      tx_full_ff <= 1'b0;
    end
  end

  // receive stage: core loads, falling read strobe fetches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_ff <= 1'b0;
      rx_ff <= 8'h00;
    end else if (rd_take) begin
      rx_full_ff <= 1'b0; // RQ11
    end else if (rx_load && !rx_full_ff) begin
      rx_full_ff <= 1'b1;
      rx_ff <= rx_byte;
    end
  end

  // presented byte advances only when a byte was there to fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= 8'h00;
    end else if (rd_take) begin
      out_ff <= rx_ff; // RQ11
    end
  end

  assign pins.txe_n = tx_full_ff; // RQ8
  assign pins.rxf_n = ~rx_full_ff; // RQ9
  assign pins.dout = out_ff;
  assign pins.dout_en = ~pins.rd_n; // RQ11
  assign tx_byte = tx_ff;
  assign tx_valid = tx_full_ff;
  assign rx_room = ~rx_full_ff;

endmodule // fifo_strobe_port

// ---- pad_router.sv ----
`timescale 1ns/1ps
`include "pad_router_regs.svh"

// Contract
// RQ1: each peripheral signal sits in one group
// RQ2: group reaches only pads with index mod four
// RQ3: configurer picks the pad within the group
// RQ4: each pad input, output or two-way
// RQ5: reset leaves every pad input, undriven
// RQ6: enabling loads the package default assignment
// RQ7: configurer keeps debug on pad zero; a write to pad 0 may select any slot, nothing locks it
// RQ8: transmit flag high forbids writes
// RQ9: receive flag low when a byte waits
// RQ10: falling write strobe captures data byte
// RQ11: read strobe low drives byte, fall fetches
// RQ12: transmit-active output enables line driver
// RQ13: serial handshake inputs in, outputs out
// RQ14: slave host-out two-way, host-in out only
// RQ15: master drives two active-low selects
// RQ16: hash-marked signals are active low
// RQ17: output pad drives only its one slot
module pad_router #(
  parameter int NUM_PADS = 44,
  // per-pad {dir, sel}, pad 0 in the low bits; default all two-way slot 0
  parameter logic [NUM_PADS*6-1:0] DEFAULT_CFG = {NUM_PADS{6'h20}}
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic router_enable,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_pad,
  input wire logic [1:0] cfg_dir,
  input wire logic [3:0] cfg_sel,
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  input wire logic [63:0] periph_out,
  input wire logic [63:0] periph_oe,
  output logic [63:0] periph_in,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_pop,
  input wire logic [7:0] rx_byte,
  input wire logic rx_load,
  output logic rx_room
);

  // reset release synchroniser
  logic rst_a_ff; // first stage, read only by the second
  logic rst_b_ff; // released copy used everywhere
  wire rst_n = rst_b_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  // per-pad routing state
  pad_router_pkg::pad_cfg_s cfg_ff [NUM_PADS]; // stored choice
  logic en_prev_ff; // enable level last cycle
  logic [NUM_PADS-1:0] pad_out_ff; // registered pad value
  logic [NUM_PADS-1:0] pad_oe_ff; // registered pad drive enable
  logic [63:0] periph_in_ff; // registered slot inputs

  // enable edge reloads the defaults
  wire en_rise = router_enable & ~en_prev_ff;
  wire wr_hit = cfg_write & (int'(cfg_pad) < NUM_PADS);
  // illegal direction code falls back to input, never to drive
  wire pad_router_pkg::pad_dir_e wr_dir =
    (cfg_dir == 2'h1) ? pad_router_pkg::PAD_OUTPUT :
    (cfg_dir == 2'h2) ? pad_router_pkg::PAD_BIDIR :
                        pad_router_pkg::PAD_INPUT;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_ff <= 1'b0;
    end else begin
      en_prev_ff <= router_enable;
    end
  end

  // configuration store; the default load wins over a same-cycle write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PADS; p++) begin
        cfg_ff[p].dir <= pad_router_pkg::PAD_INPUT; // RQ5
        cfg_ff[p].sel <= `PR_SEL_RESET;
      end
    end else if (en_rise) begin
      for (int p = 0; p < NUM_PADS; p++) begin
        cfg_ff[p] <= pad_router_pkg::pad_cfg_s'(DEFAULT_CFG[p*6 +: 6]); // RQ6
      end
    end else if (wr_hit) begin
      cfg_ff[cfg_pad].dir <= wr_dir; // RQ4
      cfg_ff[cfg_pad].sel <= cfg_sel; // RQ3
    end
  end

  // parallel port joined to its slots
  fifo_strobe_if fifo_bus ();
  logic [63:0] slot_out; // slot values offered to the pads
  logic [63:0] slot_oe; // slot drive requests for two-way pads
  logic [63:0] slot_in; // slot values gathered from the pads

  assign fifo_bus.wr_n = periph_in_ff[`PR_SLOT_WR_N];
  assign fifo_bus.rd_n = periph_in_ff[`PR_SLOT_RD_N];
  assign fifo_bus.din = {periph_in_ff[`PR_SLOT_D7],
                         periph_in_ff[`PR_SLOT_D6],
                         periph_in_ff[`PR_SLOT_D5],
                         periph_in_ff[`PR_SLOT_D4],
                         periph_in_ff[`PR_SLOT_D3],
                         periph_in_ff[`PR_SLOT_D2],
                         periph_in_ff[`PR_SLOT_D1],
                         periph_in_ff[`PR_SLOT_D0]};

  fifo_strobe_port u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .pins(fifo_bus.engine),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid),
    .tx_pop(tx_pop),
    .rx_byte(rx_byte),
    .rx_load(rx_load),
    .rx_room(rx_room)
  );

  // slot values: peripherals outside, parallel port slots from inside
  always_comb begin
    slot_out = periph_out;
    slot_oe = periph_oe;
    // line-driver enable and master selects always request drive
    slot_oe[`PR_SLOT_TX_ACTIVE] = 1'b1; // RQ12
    slot_oe[`PR_SLOT_HOST_SEL_A_N] = 1'b1; // RQ15
    slot_oe[`PR_SLOT_HOST_SEL_B_N] = 1'b1; // RQ15
    slot_out[`PR_SLOT_TXE_N] = fifo_bus.txe_n; // RQ8
    slot_out[`PR_SLOT_RXF_N] = fifo_bus.rxf_n; // RQ9
    slot_oe[`PR_SLOT_TXE_N] = 1'b1;
    slot_oe[`PR_SLOT_RXF_N] = 1'b1;
    slot_out[`PR_SLOT_D0] = fifo_bus.dout[0];
    slot_out[`PR_SLOT_D1] = fifo_bus.dout[1];
    slot_out[`PR_SLOT_D2] = fifo_bus.dout[2];
    slot_out[`PR_SLOT_D3] = fifo_bus.dout[3];
    slot_out[`PR_SLOT_D4] = fifo_bus.dout[4];
    slot_out[`PR_SLOT_D5] = fifo_bus.dout[5];
    slot_out[`PR_SLOT_D6] = fifo_bus.dout[6];
    slot_out[`PR_SLOT_D7] = fifo_bus.dout[7];
    slot_oe[`PR_SLOT_D0] = fifo_bus.dout_en; // RQ11
    slot_oe[`PR_SLOT_D1] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D2] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D3] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D4] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D5] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D6] = fifo_bus.dout_en;
    slot_oe[`PR_SLOT_D7] = fifo_bus.dout_en;
  end

  // one lane per pad, wired to the group of its index
  logic [NUM_PADS-1:0] lane_val; // lane drive value
  logic [NUM_PADS-1:0] lane_en; // lane drive enable
  logic [NUM_PADS-1:0] lane_rx; // lane listens
  pad_router_pkg::pad_dir_e eff_dir [NUM_PADS]; // direction in force

  for (genvar p = 0; p < NUM_PADS; p++) begin : g_lane
    // a disabled router leaves every pad an input
    assign eff_dir[p] = router_enable ? cfg_ff[p].dir
                                      : pad_router_pkg::PAD_INPUT; // RQ5
    pad_lane #(
      .GROUP(p % `PR_NUM_GROUPS) // RQ1
    ) u_lane (
      .group_out(slot_out[(p % 4) * 16 +: 16]), // RQ2
      .group_oe(slot_oe[(p % 4) * 16 +: 16]), // RQ2
      .dir(eff_dir[p]),
      .sel(cfg_ff[p].sel),
      .drive_val(lane_val[p]),
      .drive_en(lane_en[p]),
      .rx_en(lane_rx[p])
    );
  end

  // gather inputs; lowest listening pad wins if several pick one slot
  always_comb begin
    slot_in = `PR_IN_IDLE; // RQ16
    for (int p = NUM_PADS - 1; p >= 0; p--) begin
      if (lane_rx[p]) begin
        slot_in[(p % 4) * 16 + int'(cfg_ff[p].sel)] = pad_in[p]; // RQ2
      end
    end
  end

  // pad and slot outputs come from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0; // RQ5
      periph_in_ff <= `PR_IN_IDLE; // RQ16
    end else begin
      pad_out_ff <= lane_val;
      pad_oe_ff <= lane_en; // RQ17
      periph_in_ff <= slot_in; // RQ13
    end
  end

  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign periph_in = periph_in_ff;

endmodule // pad_router

// ---- pad_world.sv ----
`timescale 1ns/1ps
// far-side devices on the pads; an unheld line wanders
module pad_world #(
  parameter int N = 44
) (
  input wire logic clk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_en,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] wander_ff = '0; // no pull, so a free line flips
  always @(posedge clk) begin
    wander_ff <= ~wander_ff;
  end
  // device drive wins, else the far side, else the wandering level
  assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_val
    | ~ext_en & wander_ff);
endmodule // pad_world

// ---- pad_router_sva.sv ----
`timescale 1ns/1ps
`include "pad_router_regs.svh"
// port checker for the pad router
module pad_router_sva #(
  parameter int NUM_PADS = 44
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic router_enable,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_pad,
  input wire logic [1:0] cfg_dir,
  input wire logic [3:0] cfg_sel,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [63:0] periph_in,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_pop,
  input wire logic rx_load,
  input wire logic rx_room
);
  default clocking cb @(posedge ref_clk);
  endclocking
  // the first reset edge only settles the flops, so watch from the second
  logic in_rst_ff = 1'b0; // reset was seen at the last edge
  always @(posedge ref_clk) begin
    in_rst_ff <= !resetn;
  end
  // reset is asynchronous, so these hold at every later edge it is low
  a_reset_quiet: assert property (!resetn && in_rst_ff
    |-> pad_oe == '0) else $error("pad driven in reset");
  a_reset_stages: assert property (!resetn && in_rst_ff
    |-> !tx_valid && rx_room && periph_in == `PR_IN_IDLE)
    else $error("bad reset state");
  a_off_quiet: assert property (disable iff (!resetn)
    !router_enable [*3] |-> pad_oe == '0) else $error("pad on, disabled");
  a_cfg_input: assert property (disable iff (!resetn)
    cfg_write && cfg_dir != 2'h1 && cfg_dir != 2'h2 && cfg_pad < NUM_PADS
    && router_enable && $past(router_enable)
    ##1 (router_enable && !cfg_write) [*3] |-> !pad_oe[$past(cfg_pad, 3)])
    else $error("input pad driven");
  a_cfg_output: assert property (disable iff (!resetn)
    cfg_write && cfg_pad == 6'h00 && cfg_dir == 2'h1 && cfg_sel == 4'h0
    && router_enable && $past(router_enable) && $past(resetn, 2)
    ##1 (router_enable && !cfg_write) [*3] |-> pad_oe[0])
    else $error("output pad idle");
  a_tx_hold: assert property (disable iff (!resetn)
    tx_valid && !tx_pop |=> tx_valid && $stable(tx_byte))
    else $error("full stage changed");
  a_tx_pop_frees: assert property (disable iff (!resetn)
    tx_valid && tx_pop |=> !tx_valid) else $error("pop ignored");
  a_rx_take: assert property (disable iff (!resetn)
    resetn && $past(resetn, 2) && rx_room && rx_load |=> !rx_room)
    else $error("load ignored");
  // main scenarios reached
  c_capture: cover property (disable iff (!resetn) $rose(tx_valid));
  c_load: cover property (disable iff (!resetn) rx_room && rx_load);
  c_enable: cover property (disable iff (!resetn) $rose(router_enable));
endmodule // pad_router_sva

bind pad_router pad_router_sva #(.NUM_PADS(NUM_PADS)) chk_i (.ref_clk,
  .resetn, .router_enable, .cfg_write, .cfg_pad, .cfg_dir, .cfg_sel,
  .pad_oe, .periph_in, .tx_byte, .tx_valid, .tx_pop, .rx_load, .rx_room);

// ---- pad_router_tb.sv ----
`timescale 1ns/1ps
`include "pad_router_regs.svh"
// bench: configures the router and plays the parallel-port host
module pad_router_tb;
  localparam int NP = 44;
  localparam logic [15:0] OCAP [4] = '{`PR_G0_OUT_CAP, `PR_G1_OUT_CAP,
    `PR_G2_OUT_CAP, `PR_G3_OUT_CAP}; // drive-capable slots per group
  // pads 3..14: wr_n, d0..d7, rxf_n, txe_n, rd_n
  localparam logic [1:0] FD [12] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
  localparam logic [3:0] FS [12] = '{4'h4, 4'h1, 4'h2, 4'h1, 4'h2, 4'h2,
    4'h3, 4'h2, 4'h3, 4'h6, 4'h4, 4'h3};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0; // active low
  logic router_enable = 1'b0;
  logic cfg_write = 1'b0;
  logic [5:0] cfg_pad = 6'h00;
  logic [1:0] cfg_dir = 2'h0;
  logic [3:0] cfg_sel = 4'h0;
  logic [NP-1:0] pad_in, pad_out, pad_oe;
  logic [NP-1:0] ext_val = '1; // strobes idle high
  logic [NP-1:0] ext_en = '1; // far side holds every released pad
  logic [63:0] periph_out = 64'h0, periph_oe = 64'h0, periph_in;
  logic [7:0] tx_byte, b;
  logic [7:0] rx_byte = 8'h00;
  logic tx_valid, rx_room, tx_d;
  logic tx_pop = 1'b0;
  logic rx_load = 1'b0;
  logic [7:0] exp_q[$]; // bytes a write strobe should capture
  int err_total = 0;
  int n_tests = 0;

  always #20 ref_clk = ~ref_clk; // 25 MHz

  pad_router #(.NUM_PADS(NP)) dut (.ref_clk, .resetn, .router_enable,
    .cfg_write, .cfg_pad, .cfg_dir, .cfg_sel, .pad_in, .pad_out, .pad_oe,
    .periph_out, .periph_oe, .periph_in, .tx_byte, .tx_valid, .tx_pop,
    .rx_byte, .rx_load, .rx_room);
  pad_world #(.N(NP)) far (.clk(ref_clk), .pad_out, .pad_oe, .ext_val,
    .ext_en, .pad_in);

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // pulses drop here; callers pass an edge first
  task automatic idle(input int n);
    cfg_write <= 1'b0;
    tx_pop <= 1'b0;
    rx_load <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic cfg(input int p, input logic [1:0] d, input logic [3:0] s);
    cfg_write <= 1'b1;
    cfg_pad <= 6'(p);
    cfg_dir <= d;
    cfg_sel <= s;
    @(posedge ref_clk);
  endtask

  // a pad drives only its own group's slot, and only if that slot can
  task automatic chk_pad(input int k, input logic [1:0] d,
                         input logic [3:0] s);
    logic e;
    e = OCAP[k%4][s] && (d == 2'h1 || d == 2'h2 && periph_oe[k%4*16+s]);
    chk(pad_oe[k], e);
    if (e) chk(pad_out[k], periph_out[k%4*16+s]);
  endtask

  // one write strobe; a write while full is meant to be dropped
  task automatic wr(input logic [7:0] v, input logic take);
    ext_val[11:4] <= v;
    if (take) exp_q.push_back(v);
    @(posedge ref_clk);
    ext_val[3] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_val[3] <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  // each fresh capture takes the oldest note; negedge sees settled flops
  always @(negedge ref_clk) begin
    tx_d <= tx_valid;
    if (tx_valid === 1'b1 && tx_d === 1'b0) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0);
      else chk(tx_byte, exp_q.pop_front());
    end
  end

  initial begin
    int k;
    logic [1:0] d;
    logic [3:0] s;
    void'($urandom(28396));
    repeat (2) @(posedge ref_clk);
    chk(pad_oe, '0);
    chk(periph_in, `PR_IN_IDLE);
    chk({tx_valid, rx_room}, 2'h1);
    @(posedge ref_clk);
    resetn <= 1'b1;
    periph_out <= {$urandom, $urandom};
    periph_oe <= {$urandom, $urandom};
    repeat (3) @(posedge ref_clk);
    router_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (k = 0; k < NP; k++) chk_pad(k, 2'h2, 4'h0);
    cfg(0, 2'h1, 4'h0);
    idle(3);
    chk_pad(0, 2'h1, 4'h0);
    // random pads and directions, free-running slots only
    repeat (16) begin
      k = 16 + $urandom % 28;
      d = 2'($urandom % 4);
      s = 4'(11 + $urandom % 5);
      cfg(k, d, s);
      idle(3);
      chk_pad(k, d, s);
    end
    router_enable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(pad_oe, '0);
    router_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (k = 0; k < NP; k++) chk_pad(k, 2'h2, 4'h0);
    // forced drivers and slave data directions
    cfg(16, 2'h2, 4'h5);
    cfg(17, 2'h2, 4'h5);
    cfg(18, 2'h0, 4'h6);
    cfg(19, 2'h2, 4'h7);
    idle(3);
    chk({pad_oe[19], pad_oe[16]}, 2'h3);
    chk(pad_out[16], periph_out[5]);
    chk(pad_out[19], periph_out[55]);
    chk(pad_oe[17], periph_oe[21]);
    chk(periph_in[21], periph_oe[21] ? periph_out[21] : 1'b1);
    chk({pad_oe[18], periph_in[38]}, 2'h0);
    for (k = 0; k < 12; k++) cfg(3 + k, FD[k], FS[k]);
    idle(4);
    chk(periph_in[52], 1'b1);
    chk(pad_out[13:12], 2'h1);
    chk(pad_oe[14:12], 3'h3);
    b = 8'($urandom);
    wr(b, 1'b1);
    chk(pad_out[13], 1'b1);
    wr(~b, 1'b0);
    tx_pop <= 1'b1;
    @(posedge ref_clk);
    idle(3);
    chk(pad_out[13], 1'b0);
    wr(8'($urandom), 1'b1);
    rx_byte <= 8'($urandom);
    rx_load <= 1'b1;
    @(posedge ref_clk);
    b = rx_byte;
    idle(4);
    chk({rx_room, pad_out[12]}, 2'h0);
    ext_en[11:4] <= 8'h00; // far side lets go of the data pads
    ext_val[14] <= 1'b0; // read strobe falls
    repeat (4) @(posedge ref_clk);
    chk(pad_oe[11:4], 8'hFF);
    chk(pad_out[11:4], b);
    chk(rx_room, 1'b1);
    ext_val[14] <= 1'b1;
    ext_en[11:4] <= 8'hFF;
    repeat (4) @(posedge ref_clk);
    chk(exp_q.size(), 0);
    close_out();
  end
endmodule // pad_router_tb
